// file: rtl/receive_signaling_payload_control.sv
// receive payload conditioner: apb registers, indirect access engine, signaling path
//
// What this block does
// - conditioning acts only with link enable set
// - snapshot, then trunk, then placement, fixed priority
// - signaling in upper two or whole nibble
// - first-frame signaling held for multiframe, not DM
// - global trunk enable replaces all channel ABCD
// - otherwise only channels with own enable
// - seven-bit address selects indirect register
// - direction bit, eight-bit data register path
// - busy status per link for indirect access
// - eight register copies, 0x100 index stride
// - signaling trunk codes at mapped indirect addresses
// - data trunk codes at mapped indirect addresses
// - channel control bits at mapped indirect addresses
module receive_signaling_payload_control
  import rx_sig_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // line mode from framer
  input wire logic e1_mode,
  input wire logic esf_slc_format,
  input wire logic t1dm_format,
  // received signaling stream
  input wire logic sig_in_valid,
  input wire logic [LINK_W-1:0] sig_in_link,
  input wire logic [CH_W-1:0] sig_in_channel,
  input wire logic [3:0] sig_in_abcd,
  input wire logic sig_in_first_frame,
  // receive_signaling_output stream
  output logic sig_out_valid,
  output logic [LINK_W-1:0] sig_out_link,
  output logic [CH_W-1:0] sig_out_channel,
  output logic [3:0] sig_out_nibble
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0] test_cfg_q [0:LINKS-1];
  logic [7:0] acc_ctrl_q [0:LINKS-1];
  logic [7:0] acc_data_q [0:LINKS-1];
  logic [7:0] payload_cfg_q [0:LINKS-1];
  logic [7:0] ctrl_en_q [0:LINKS-1];
  logic [LINKS-1:0] busy_q;
  logic [LINKS-1:0] busy_d;

  engine_state_t st_q;
  logic [LINK_W-1:0] eng_link_q;
  logic [IND_ADDR_W-1:0] eng_addr_q;
  logic eng_rnw_q;
  logic [7:0] ram_rdata;
  logic [7:0] trunk_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire logic [10:0] reg_index = paddr[APB_ADDR_W-1:2];
  wire logic [LINK_W-1:0] acc_link = reg_index[10:8];
  wire logic [7:0] acc_off = reg_index[7:0];
  wire logic aligned = (paddr[1:0] == 2'b00);
  wire logic hit_test = aligned && (acc_off == REG_TEST_CFG);
  wire logic hit_stat = aligned && (acc_off == REG_ACC_STAT);
  wire logic hit_ctrl = aligned && (acc_off == REG_ACC_CTRL);
  wire logic hit_data = aligned && (acc_off == REG_ACC_DATA);
  wire logic hit_cfg = aligned && (acc_off == REG_PAYLOAD_CFG);
  wire logic hit_en = aligned && (acc_off == REG_CTRL_EN);
  wire logic hit_any = hit_test || hit_stat || hit_ctrl || hit_data || hit_cfg || hit_en;
  wire logic setup_ph = psel && !penable;
  // writes land on the access edge; pready is already high then
  wire logic wr_now = psel && penable && pwrite && pready && hit_any;
  wire logic [7:0] wbyte = pwdata[7:0];

  wire logic [7:0] rd_byte =
    hit_test ? test_cfg_q[acc_link] :
    hit_stat ? {7'h00, busy_q[acc_link]} :
    hit_ctrl ? acc_ctrl_q[acc_link] :
    hit_data ? acc_data_q[acc_link] :
    hit_cfg ? payload_cfg_q[acc_link] :
    hit_en ? ctrl_en_q[acc_link] : 8'h00;

  // zero wait state: answer prepared in setup, presented in access
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !hit_any;
      prdata <= setup_ph ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indirect access engine

  wire logic [LINKS-1:0] busy_set = (wr_now && hit_ctrl) ? (8'h01 << acc_link) : 8'h00;
  wire logic [LINKS-1:0] busy_clr = (st_q == ENG_DONE) ? (8'h01 << eng_link_q) : 8'h00;
  // a new request beats the completion of the previous one on the same link
  assign busy_d = (busy_q & ~busy_clr) | busy_set;
  wire logic [LINK_W-1:0] next_link = lowest_link(busy_q);
  wire logic eng_addr_ok = indirect_addr_valid(eng_addr_q, e1_mode);
  wire logic ram_a_en = (st_q == ENG_ACCESS);
  wire logic ram_a_we = ram_a_en && !eng_rnw_q && eng_addr_ok;
  wire logic hw_data_wr = (st_q == ENG_DONE) && eng_rnw_q;
  wire logic [7:0] hw_data = eng_addr_ok ? ram_rdata : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= ENG_IDLE;
      eng_link_q <= '0;
      eng_addr_q <= '0;
      eng_rnw_q <= 1'b0;
    end else begin
      case (st_q)
        ENG_IDLE: begin
          if (|busy_q) begin
            eng_link_q <= next_link;
            eng_addr_q <= acc_ctrl_q[next_link][IND_ADDR_W-1:0];
            eng_rnw_q <= acc_ctrl_q[next_link][ACC_RNW_BIT];
            st_q <= ENG_ACCESS;
          end
        end
        ENG_ACCESS: begin
          st_q <= ENG_DONE;
        end
        ENG_DONE: begin
          st_q <= ENG_IDLE;
        end
        default: begin
          st_q <= ENG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busy_q <= '0;
    end else begin
      busy_q <= busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-link direct registers

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < LINKS; i++) begin
        test_cfg_q[i] <= REG_RESET;
        acc_ctrl_q[i] <= REG_RESET;
        acc_data_q[i] <= REG_RESET;
        payload_cfg_q[i] <= REG_RESET;
        ctrl_en_q[i] <= REG_RESET;
      end
    end else begin
      for (int i = 0; i < LINKS; i++) begin
        if (wr_now && (acc_link == i[2:0])) begin
          if (hit_test) begin
            test_cfg_q[i] <= wbyte;
          end
          if (hit_ctrl) begin
            acc_ctrl_q[i] <= wbyte;
          end
          if (hit_data) begin
            acc_data_q[i] <= wbyte;
          end
          if (hit_cfg) begin
            payload_cfg_q[i] <= wbyte;
          end
          if (hit_en) begin
            ctrl_en_q[i] <= wbyte;
          end
        end
        // returned read data wins over a simultaneous software write
        if (hw_data_wr && (eng_link_q == i[2:0])) begin
          acc_data_q[i] <= hw_data;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indirect storage and signaling path

  logic [LINKS-1:0] payload_conditioning_enable_v;
  logic [LINKS-1:0] snap_v;
  logic [LINKS-1:0] gstrk_v;
  logic [LINKS-1:0] signaling_position_select_v;

  always_comb begin
    for (int i = 0; i < LINKS; i++) begin
      payload_conditioning_enable_v[i] = ctrl_en_q[i][EN_PAYLOAD_CONDITIONING_ENABLE_BIT];
      snap_v[i] = payload_cfg_q[i][CFG_SNAP_BIT];
      gstrk_v[i] = payload_cfg_q[i][CFG_GSTRK_BIT];
      signaling_position_select_v[i] = ctrl_en_q[i][EN_SIGNALING_POSITION_SELECT_BIT];
    end
  end

  // the stream port only reads the signaling trunk area of each link
  wire logic [IND_ADDR_W-1:0] trunk_addr = TRUNK_SIG_BASE | {2'b00, sig_in_channel};

  sync_ram #(.AW(LINK_W + IND_ADDR_W), .DW(8)) u_indirect (
    .clk_sys(clk_sys),
    .a_en(ram_a_en),
    .a_we(ram_a_we),
    .a_addr({eng_link_q, eng_addr_q}),
    .a_wdata(acc_data_q[eng_link_q]),
    .a_rdata(ram_rdata),
    .b_en(sig_in_valid),
    .b_we(1'b0),
    .b_addr({sig_in_link, trunk_addr}),
    .b_wdata(8'h00),
    .b_rdata(trunk_rdata)
  );

  signaling_conditioner u_cond (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(sig_in_valid),
    .in_link(sig_in_link),
    .in_channel(sig_in_channel),
    .in_abcd(sig_in_abcd),
    .in_first_frame(sig_in_first_frame),
    .e1_mode(e1_mode),
    .esf_slc_format(esf_slc_format),
    .t1dm_format(t1dm_format),
    .payload_conditioning_enable(payload_conditioning_enable_v),
    .snap_en(snap_v),
    .gstrk(gstrk_v),
    .signaling_position_select(signaling_position_select_v),
    .trunk_byte(trunk_rdata),
    .out_valid(sig_out_valid),
    .out_link(sig_out_link),
    .out_channel(sig_out_channel),
    .out_nibble(sig_out_nibble)
  );

endmodule

// file: rtl/rx_sig_pkg.sv
// package: register map, field layout and shared types of the receive signaling payload block
package rx_sig_pkg;

  localparam int LINKS = 8;
  localparam int LINK_W = 3;
  localparam int CH_W = 5;
  localparam int IND_ADDR_W = 7;
  localparam int APB_ADDR_W = 13;

  // register index = link * stride + offset; byte address = 4 * index
  localparam logic [10:0] LINK_STRIDE = 11'h100;
  localparam logic [7:0] REG_TEST_CFG = 8'hc7;
  localparam logic [7:0] REG_ACC_STAT = 8'hcd;
  localparam logic [7:0] REG_ACC_CTRL = 8'hce;
  localparam logic [7:0] REG_ACC_DATA = 8'hcf;
  localparam logic [7:0] REG_PAYLOAD_CFG = 8'hd0;
  localparam logic [7:0] REG_CTRL_EN = 8'hd1;
  localparam logic [7:0] REG_RESET = 8'h00;

  // field positions
  localparam int ACC_RNW_BIT = 7;
  localparam int ACC_BUSY_BIT = 0;
  localparam int CFG_SNAP_BIT = 0;
  localparam int CFG_GSTRK_BIT = 1;
  localparam int EN_PAYLOAD_CONDITIONING_ENABLE_BIT = 0;
  localparam int EN_SIGNALING_POSITION_SELECT_BIT = 1;
  localparam int STRK_EN_BIT = 4;

  // indirect map
  localparam logic [6:0] TRUNK_SIG_BASE = 7'h40;
  localparam logic [6:0] DATA_TRUNK_BASE = 7'h20;
  localparam logic [6:0] CH_CTRL_BASE = 7'h00;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_ACCESS = 3'b010,
    ENG_DONE = 3'b100
  } engine_state_t;

  // mapped indirect locations depend on line mode
  function automatic logic indirect_addr_valid(input logic [6:0] a, input logic e1);
    logic [4:0] low;
    logic [1:0] blk;
    low = a[4:0];
    blk = a[6:5];
    if (e1) begin
      indirect_addr_valid = (blk == CH_CTRL_BASE[6:5]) || (blk == DATA_TRUNK_BASE[6:5]) ||
                            ((blk == TRUNK_SIG_BASE[6:5]) && (low != 5'h00) && (low != 5'h10));
    end else begin
      indirect_addr_valid = (blk != 2'b11) && (low >= 5'h01) && (low <= 5'h18);
    end
  endfunction

  function automatic logic [2:0] lowest_link(input logic [7:0] v);
    lowest_link = 3'h0;
    for (int i = LINKS - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest_link = i[2:0];
      end
    end
  endfunction

endpackage

// file: rtl/sync_ram.sv
// true dual-port memory with registered read data on both ports
module sync_ram #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  // clock
  input wire logic clk_sys,
  // port a
  input wire logic a_en,
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  // port b
  input wire logic b_en,
  input wire logic b_we,
  input wire logic [AW-1:0] b_addr,
  input wire logic [DW-1:0] b_wdata,
  output logic [DW-1:0] b_rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // contents are not reset: software must program before enabling
  always_ff @(posedge clk_sys) begin
    if (a_en && a_we) begin
      mem[a_addr] <= a_wdata;
    end
    if (a_en) begin
      a_rdata <= mem[a_addr];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (b_en && b_we) begin
      mem[b_addr] <= b_wdata;
    end
    if (b_en) begin
      b_rdata <= mem[b_addr];
    end
  end

endmodule

// file: rtl/signaling_conditioner.sv
// signaling stream path: snapshot, trunk replacement and nibble placement
module signaling_conditioner
  import rx_sig_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // incoming signaling
  input wire logic in_valid,
  input wire logic [LINK_W-1:0] in_link,
  input wire logic [CH_W-1:0] in_channel,
  input wire logic [3:0] in_abcd,
  input wire logic in_first_frame,
  // mode
  input wire logic e1_mode,
  input wire logic esf_slc_format,
  input wire logic t1dm_format,
  // per-link configuration
  input wire logic [LINKS-1:0] payload_conditioning_enable,
  input wire logic [LINKS-1:0] snap_en,
  input wire logic [LINKS-1:0] gstrk,
  input wire logic [LINKS-1:0] signaling_position_select,
  // channel trunk byte, one cycle after in_valid
  input wire logic [7:0] trunk_byte,
  // conditioned output
  output logic out_valid,
  output logic [LINK_W-1:0] out_link,
  output logic [CH_W-1:0] out_channel,
  output logic [3:0] out_nibble
);

  logic s1_valid_q;
  logic [LINK_W-1:0] s1_link_q;
  logic [CH_W-1:0] s1_ch_q;
  logic [3:0] s1_abcd_q;
  logic s1_first_q;
  logic [3:0] snap_rdata;

  wire logic snap_wr = in_valid && in_first_frame && payload_conditioning_enable[in_link] && snap_en[in_link] && !t1dm_format;
  wire logic on = payload_conditioning_enable[s1_link_q];
  wire logic snap_use = on && snap_en[s1_link_q] && !t1dm_format && !s1_first_q;
  wire logic [3:0] src = snap_use ? snap_rdata : s1_abcd_q;
  wire logic trunk_on = on && (gstrk[s1_link_q] || trunk_byte[STRK_EN_BIT]);
  wire logic [3:0] after_trunk = trunk_on ? trunk_byte[3:0] : src;
  wire logic pos_two = on && signaling_position_select[s1_link_q] && !e1_mode && esf_slc_format;
  // placement is applied last so its layout always stands over the earlier substitutions
  wire logic [3:0] nibble = pos_two ? {after_trunk[3:2], 2'b00} : after_trunk;

  // snapshot store: one nibble per link and channel
  sync_ram #(.AW(LINK_W + CH_W), .DW(4)) u_snap (
    .clk_sys(clk_sys),
    .a_en(1'b0),
    .a_we(1'b0),
    .a_addr('0),
    .a_wdata(4'h0),
    .a_rdata(),
    .b_en(in_valid),
    .b_we(snap_wr),
    .b_addr({in_link, in_channel}),
    .b_wdata(in_abcd),
    .b_rdata(snap_rdata)
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_valid_q <= 1'b0;
      s1_link_q <= '0;
      s1_ch_q <= '0;
      s1_abcd_q <= 4'h0;
      s1_first_q <= 1'b0;
    end else begin
      s1_valid_q <= in_valid;
      s1_link_q <= in_link;
      s1_ch_q <= in_channel;
      s1_abcd_q <= in_abcd;
      s1_first_q <= in_first_frame;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_link <= '0;
      out_channel <= '0;
      out_nibble <= 4'h0;
    end else begin
      out_valid <= s1_valid_q;
      out_link <= s1_link_q;
      out_channel <= s1_ch_q;
      out_nibble <= nibble;
    end
  end

endmodule

// file: tb/rx_sig_checker.sv
// checker: apb answer and signaling stream timing of the payload block
module rx_sig_checker
  import rx_sig_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // stream
  input wire logic sig_in_valid,
  input wire logic [LINK_W-1:0] sig_in_link,
  input wire logic [CH_W-1:0] sig_in_channel,
  input wire logic sig_out_valid,
  input wire logic [LINK_W-1:0] sig_out_link,
  input wire logic [CH_W-1:0] sig_out_channel
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access accepted");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_out_latency: assert property (sig_in_valid |-> ##2 sig_out_valid)
    else $error("nibble lost or late");
  a_out_cause: assert property (sig_out_valid |-> $past(sig_in_valid, 2))
    else $error("nibble without input");
  a_slot_kept: assert property (sig_out_valid |-> sig_out_channel == $past(sig_in_channel, 2)
    && sig_out_link == $past(sig_in_link, 2))
    else $error("channel or link changed");
  ////////////////////////////////////////
  c_stream: cover property (sig_out_valid);
  c_refused: cover property (pready && pslverr);
  c_read_data: cover property (pready && prdata != 32'h0);
endmodule

bind receive_signaling_payload_control rx_sig_checker chk_i (.clk_sys, .sys_rst, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .sig_in_valid, .sig_in_link, .sig_in_channel,
  .sig_out_valid, .sig_out_link, .sig_out_channel);

// file: tb/sig_sink.sv
// partner: backplane sink that records each conditioned nibble
module sig_sink
  import rx_sig_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // stream from the block
  input wire logic sig_out_valid,
  input wire logic [CH_W-1:0] sig_out_channel,
  input wire logic [3:0] sig_out_nibble,
  // captured
  output logic [CH_W-1:0] got_ch,
  output logic [3:0] got_nib,
  output int got_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial got_n = 0;
  // the backplane has no backpressure, so every pulse is taken
  always @(posedge clk_sys) begin
    if (sig_out_valid === 1'b1) begin
      got_ch <= sig_out_channel;
      got_nib <= sig_out_nibble;
      got_n <= got_n + 1;
    end
  end
endmodule

// file: tb/tb_receive_signaling_payload_control.sv
// testbench: registers, indirect window and signaling stream
module tb_receive_signaling_payload_control
  import rx_sig_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [12:0] paddr = 13'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic pready, pslverr, err_q, sig_out_valid;
  logic e1_mode = 0, esf_slc_format = 0, t1dm_format = 0;
  logic sig_in_valid = 0, sig_in_first_frame = 0;
  logic [2:0] sig_in_link = 3'h0, sig_out_link;
  logic [4:0] sig_in_channel = 5'h05, sig_out_channel, got_ch;
  logic [3:0] sig_in_abcd = 4'h0, sig_out_nibble, got_nib;
  int got_n, fail_count = 0, n_compared = 0;
  receive_signaling_payload_control uut (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .e1_mode, .esf_slc_format, .t1dm_format, .sig_in_valid,
    .sig_in_link, .sig_in_channel, .sig_in_abcd, .sig_in_first_frame, .sig_out_valid,
    .sig_out_link, .sig_out_channel, .sig_out_nibble);
  sig_sink sink (.clk_sys, .sig_out_valid, .sig_out_channel, .sig_out_nibble, .got_ch, .got_nib,
    .got_n);
  always #20 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // pready, prdata and pslverr are taken at the rising edge that ends the access phase
  task automatic apb(bit [2:0] lk, bit [7:0] off, bit wr, bit [7:0] d, bit [1:0] lo = 2'h0);
    int i;
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= wr;
    paddr <= {lk, off, lo};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      test_done();
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic ind(bit rd, bit [6:0] a, bit [7:0] d);
    int i;
    if (!rd) apb(0, REG_ACC_DATA, 1, d);
    apb(0, REG_ACC_CTRL, 1, {rd, a});
    i = 0;
    do begin
      apb(0, REG_ACC_STAT, 0, 0);
      i++;
    end while (rd_q[0] !== 1'b0 && i < 20);
    if (rd_q[0] !== 1'b0) begin
      fail_count++;
      test_done();
    end
    if (rd) apb(0, REG_ACC_DATA, 0, 0);
  endtask
  task automatic sd(bit [3:0] v, bit ff, bit [3:0] exp);
    int n, i;
    n = got_n;
    @(posedge clk_sys);
    sig_in_valid <= 1;
    sig_in_abcd <= v;
    sig_in_first_frame <= ff;
    @(posedge clk_sys);
    sig_in_valid <= 0;
    for (i = 0; i < 10 && got_n == n; i++) @(posedge clk_sys);
    if (got_n == n) begin
      fail_count++;
      test_done();
    end
    chk("channel", got_ch, 32'h5);
    chk("nibble", got_nib, exp);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    apb(0, REG_CTRL_EN, 0, 0);
    chk("ctrl_en reset", rd_q, 32'h0);
    apb(7, REG_PAYLOAD_CFG, 1, 8'ha5);
    apb(7, REG_PAYLOAD_CFG, 0, 0);
    chk("cfg link7", rd_q, 32'ha5);
    apb(0, REG_PAYLOAD_CFG, 0, 0);
    chk("cfg link0", rd_q, 32'h0);
    apb(7, REG_PAYLOAD_CFG, 1, 8'h00);
    apb(0, REG_ACC_STAT, 1, 8'hff);
    apb(0, REG_ACC_STAT, 0, 0);
    chk("status ro", rd_q, 32'h0);
    apb(0, 8'h10, 0, 0);
    chk("unmapped err", err_q, 32'h1);
    apb(0, REG_TEST_CFG, 0, 0, 2'h2);
    chk("misaligned err", err_q, 32'h1);
    $display("t_regs done");
  endtask
  task automatic t_ind();
    bit [6:0] a [3] = '{7'h41, 7'h21, 7'h01};
    bit [7:0] d [3] = '{8'h1c, 8'h5a, 8'h07};
    foreach (a[i]) begin
      ind(0, a[i], d[i]);
      ind(1, a[i], 0);
      chk("ind readback", rd_q, {24'h0, d[i]});
    end
    e1_mode <= 1;
    ind(0, 7'h00, 8'h3c);
    ind(1, 7'h00, 0);
    chk("e1 slot0", rd_q, 32'h3c);
    ind(0, 7'h50, 8'h11);
    ind(1, 7'h50, 0);
    chk("e1 hole", rd_q, 32'h0);
    e1_mode <= 0;
    ind(1, 7'h00, 0);
    chk("t1 hole", rd_q, 32'h0);
    $display("t_ind done");
  endtask
  task automatic t_strm();
    sd(4'h9, 0, 4'h9);
    ind(0, 7'h45, 8'h06);
    apb(0, REG_CTRL_EN, 1, 8'h01);
    apb(0, REG_PAYLOAD_CFG, 1, 8'h02);
    sd(4'h9, 0, 4'h6);
    apb(0, REG_PAYLOAD_CFG, 1, 8'h00);
    sd(4'h9, 0, 4'h9);
    ind(0, 7'h45, 8'h16);
    sd(4'h9, 0, 4'h6);
    ind(0, 7'h45, 8'h06);
    apb(0, REG_PAYLOAD_CFG, 1, 8'h01);
    sd(4'h3, 1, 4'h3);
    sd(4'hc, 0, 4'h3);
    t1dm_format <= 1;
    sd(4'hc, 0, 4'hc);
    t1dm_format <= 0;
    apb(0, REG_PAYLOAD_CFG, 1, 8'h00);
    apb(0, REG_CTRL_EN, 1, 8'h03);
    esf_slc_format <= 1;
    sd(4'hb, 0, 4'h8);
    ind(0, 7'h45, 8'h17);
    sd(4'hb, 0, 4'h4);
    apb(0, REG_CTRL_EN, 1, 8'h02);
    sd(4'hb, 0, 4'hb);
    $display("t_strm done");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 0;
    t_regs();
    t_ind();
    t_strm();
    test_done();
  end
endmodule
